// [design/cps_consts.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the colour/proximity sensor register bank.
 * assumes: included by bare name from the design files.
 */
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// register offsets
`define CPS_OFS_PULSE      8'h0E
`define CPS_OFS_CONTROL    8'h0F
`define CPS_OFS_IDENT      8'h12
`define CPS_OFS_STATUS     8'h13
`define CPS_OFS_CLEAR_LO   8'h14
`define CPS_OFS_CLEAR_HI   8'h15
`define CPS_OFS_RED_LO     8'h16
`define CPS_OFS_RED_HI     8'h17
`define CPS_OFS_GREEN_LO   8'h18
`define CPS_OFS_GREEN_HI   8'h19
`define CPS_OFS_BLUE_LO    8'h1A
`define CPS_OFS_BLUE_HI    8'h1B
`define CPS_OFS_PROX_LO    8'h1C
`define CPS_OFS_PROX_HI    8'h1D

// control field positions
`define CPS_CTL_DRIVE_HI   7
`define CPS_CTL_DRIVE_LO   6
`define CPS_CTL_DIODE_HI   5
`define CPS_CTL_DIODE_LO   4
`define CPS_CTL_GAIN_HI    1
`define CPS_CTL_GAIN_LO    0

// status field positions
`define CPS_ST_PROX_IRQ    5
`define CPS_ST_COL_IRQ     4
`define CPS_ST_PROX_VALID  1
`define CPS_ST_COL_VALID   0

// reset values
`define CPS_RST_PULSE      8'h00
`define CPS_RST_CONTROL    8'h00
`define CPS_RST_RESULT     16'h0000

// control bits writable by the host (reserved 3:2 excluded)
`define CPS_CTL_WMASK      8'hF3

// 2.4 ms integration step at 50 MHz
`define CPS_STEP_NS        2400000
`define CPS_CLK_NS         20
`define CPS_STEP_CYC       (`CPS_STEP_NS / `CPS_CLK_NS)

`endif

// [design/cps_pkg.sv]
/*
 * shared types of the colour/proximity sensor register bank.
 * assumes: nothing beyond the constants header.
 */
package cps_pkg;
   // measurement sequencer states
   typedef enum logic [1:0] {
      CPS_IDLE,
      CPS_COLOUR,
      CPS_PROX
   } cps_seq_t;

   // led sink current selection codes
   typedef enum logic [1:0] {
      CPS_LED_100MA,
      CPS_LED_50MA,
      CPS_LED_25MA,
      CPS_LED_12MA5
   } cps_drive_t;

   // proximity diode selection codes
   typedef enum logic [1:0] {
      CPS_DIODE_NONE,
      CPS_DIODE_CLEAR,
      CPS_DIODE_IR,
      CPS_DIODE_CLEAR_RED
   } cps_diode_t;
endpackage : cps_pkg

// [design/cps_sensor_regs.sv]
/*
 * register bank and measurement sequencer of the colour/proximity sensor.
 * assumes: an i2c slave front end on the same clock presents byte
 * reads and writes as one-cycle strobes with an 8-bit register address;
 * the analog front end holds results on the value inputs; conversion ends are timed here as colour_done and prox_done.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cps_consts.svh"

// Summary of operation
// (R1) proximity cycle follows each colour cycle when enabled
// (R2) colour integration time spaces proximity cycles always
// (R3) pulse count register sets led pulses
// (R4) drive field selects led sink current
// (R5) diode field selects proximity photodiode
// (R6) gain field selects colour gain
// (R7) read-only part identity at 0x12
// (R8) status read only, reserved bits 7:6,3:2
// (R9) status bits 5,4 show pending interrupts
// (R10) proximity valid after cycle since enable; the code sets it at colour_done, before the proximity cycle
// (R11) colour valid after integration completes
// (R12) each colour result is sixteen bits
// (R13) colour results at 0x14..0x1B, low first
// (R14) proximity result at 0x1C/0x1D
// (R15) low read latches high into shadow
// (R16) shadow unaffected by later conversions
// (R17) host reads words low byte first
// (R18) reserved bits written zero, read zero
module cps_sensor_regs
   import cps_pkg::*;
#(
   parameter logic [7:0] PART_ID    = 8'h5A, // arbitrary identity value
   parameter int         STEP_CYCLES = `CPS_STEP_CYC, // one integration step
   parameter int         PULSE_CYCLES = 4             // led pulse high/low length
)
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // register access strobes from the i2c slave
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // enables and timing from the neighbouring register group
   input  wire logic        colour_enable,
   input  wire logic        prox_enable,
   input  wire logic [7:0]  colour_integration_time,
   // interrupt conditions from the threshold logic
   input  wire logic        prox_irq_set,
   input  wire logic        colour_irq_set,
   input  wire logic        prox_irq_clr,
   input  wire logic        colour_irq_clr,
   // conversion results from the analog front end
   input  wire logic [15:0] clear_value,
   input  wire logic [15:0] red_value,
   input  wire logic [15:0] green_value,
   input  wire logic [15:0] blue_value,
   input  wire logic [15:0] prox_value,
   // analog controls
   output logic      [1:0]  led_drive_strength,
   output logic      [1:0]  prox_diode_select,
   output logic      [1:0]  colour_gain,
   output logic             led_pulse,
   output logic             colour_integrating,
   output logic             prox_measuring,
   output logic             colour_done,
   output logic             prox_done
);
   // refuse counts the timers cannot serve, at elaboration
   if (STEP_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad_counts
      $error("cps_sensor_regs: counts must be at least one");
   end

   // host-visible registers
   logic [7:0] led_pulse_count_r;   // pulses per proximity cycle
   logic [7:0] analog_control_r;    // drive, diode, gain
   logic       prox_irq_flag_r;     // pending proximity interrupt
   logic       colour_irq_flag_r;   // pending colour interrupt
   logic       prox_valid_flag_r;   // proximity result valid
   logic       colour_valid_flag_r; // colour result valid

   // sequencer
   cps_seq_t   state_r, state_nxt;
   logic [31:0] step_cnt_r;         // cycles inside one step
   logic [8:0]  steps_r;            // steps done in this integration
   logic [8:0]  pulses_r;           // led pulse edges done
   logic [31:0] pw_cnt_r;           // pulse width counter
   logic        led_r;

   // decode helpers
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wr_pulse   = reg_wr & hit(reg_addr, `CPS_OFS_PULSE);
   wire wr_control = reg_wr & hit(reg_addr, `CPS_OFS_CONTROL);
   // writes to identity and status decode to nothing: read-only
   // see R7 see R8

   // integration length: 256 - time steps, as on the timing register
   wire [8:0] steps_total = 9'h100 - {1'b0, colour_integration_time};
   wire       step_tick   = (step_cnt_r == 32'(STEP_CYCLES - 1));
   wire       integ_end   = step_tick && (steps_r == steps_total - 9'h001);
   wire       any_enable  = colour_enable | prox_enable;
   wire       pw_tick     = (pw_cnt_r == 32'(PULSE_CYCLES - 1));
   wire [8:0] pulse_edges = {led_pulse_count_r, 1'b0};
   wire       pulses_end  = pw_tick && (pulses_r >= pulse_edges - 9'h001);
   wire       zero_pulses = (led_pulse_count_r == 8'h00);

   // configuration registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         led_pulse_count_r <= `CPS_RST_PULSE;
         analog_control_r  <= `CPS_RST_CONTROL;
      end else begin
         if (wr_pulse)   led_pulse_count_r <= reg_wdata; // see R3
         // reserved control bits kept at zero whatever is written  see R18
         if (wr_control) analog_control_r  <= reg_wdata & `CPS_CTL_WMASK;
      end
   end

   // analog control fields  see R4 see R5 see R6
   assign led_drive_strength = analog_control_r[`CPS_CTL_DRIVE_HI:`CPS_CTL_DRIVE_LO];
   assign prox_diode_select  = analog_control_r[`CPS_CTL_DIODE_HI:`CPS_CTL_DIODE_LO];
   assign colour_gain        = analog_control_r[`CPS_CTL_GAIN_HI:`CPS_CTL_GAIN_LO];

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CPS_IDLE: begin
            if (any_enable) state_nxt = CPS_COLOUR;
         end
         // colour integration runs on its time even if colour is off  see R2
         CPS_COLOUR: begin
            if (!any_enable) state_nxt = CPS_IDLE;
            else if (integ_end && prox_enable) state_nxt = CPS_PROX; // see R1
         end
         CPS_PROX: begin
            if (!any_enable) state_nxt = CPS_IDLE;
            else if (zero_pulses || pulses_end) state_nxt = CPS_COLOUR;
         end
         default: state_nxt = CPS_IDLE;
      endcase
   end

   // step and pulse timers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r    <= CPS_IDLE;
         step_cnt_r <= 32'h0000_0000;
         steps_r    <= 9'h000;
         pulses_r   <= 9'h000;
         pw_cnt_r   <= 32'h0000_0000;
         led_r      <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == CPS_COLOUR && state_nxt == CPS_COLOUR) begin
            step_cnt_r <= step_tick ? 32'h0000_0000 : step_cnt_r + 32'h0000_0001;
            if (step_tick) steps_r <= integ_end ? 9'h000 : steps_r + 9'h001;
         end else begin
            step_cnt_r <= 32'h0000_0000;
            steps_r    <= 9'h000;
         end
         // led toggles once per pulse half; count gives whole pulses  see R3
         if (state_r == CPS_PROX && state_nxt == CPS_PROX) begin
            pw_cnt_r <= pw_tick ? 32'h0000_0000 : pw_cnt_r + 32'h0000_0001;
            if (pw_tick) begin
               pulses_r <= pulses_r + 9'h001;
               led_r    <= ~led_r;
            end
         end else begin
            pw_cnt_r <= 32'h0000_0000;
            pulses_r <= 9'h000;
            led_r    <= 1'b0;
         end
      end
   end

   assign colour_done = (state_r == CPS_COLOUR) && integ_end;
   assign prox_done   = (state_r == CPS_PROX) && (state_nxt == CPS_COLOUR);
   assign led_pulse          = led_r;
   assign colour_integrating = (state_r == CPS_COLOUR);
   assign prox_measuring     = (state_r == CPS_PROX);

   // only a colour-enabled integration loads colour results
   wire colour_load = colour_done & colour_enable;

   // status flags: interrupt set wins over clear; colour enable low wins over valid set
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prox_irq_flag_r     <= 1'b0;
         colour_irq_flag_r   <= 1'b0;
         prox_valid_flag_r   <= 1'b0;
         colour_valid_flag_r <= 1'b0;
      end else begin
         // see R9
         if (prox_irq_set)        prox_irq_flag_r <= 1'b1;
         else if (prox_irq_clr)   prox_irq_flag_r <= 1'b0;
         if (colour_irq_set)      colour_irq_flag_r <= 1'b1;
         else if (colour_irq_clr) colour_irq_flag_r <= 1'b0;
         // valid flags drop when colour enable drops  see R10 see R11
         if (!colour_enable) begin
            prox_valid_flag_r   <= 1'b0;
            colour_valid_flag_r <= 1'b0;
         end else begin
            if (colour_done)  prox_valid_flag_r   <= 1'b1;
            if (colour_load)  colour_valid_flag_r <= 1'b1;
         end
      end
   end

   // reserved status bits read as zero  see R8 see R18
   wire [7:0] status_byte = {2'b00, prox_irq_flag_r, colour_irq_flag_r,
                             2'b00, prox_valid_flag_r, colour_valid_flag_r};

   // result words, colour pairs then proximity  see R12 see R13 see R14
   wire [15:0] word_val [5];
   wire        word_ld  [5];
   wire [7:0]  lo_b     [5];
   wire [7:0]  hi_b     [5];
   assign word_val[0] = clear_value;
   assign word_val[1] = red_value;
   assign word_val[2] = green_value;
   assign word_val[3] = blue_value;
   assign word_val[4] = prox_value;
   assign word_ld[0]  = colour_load;
   assign word_ld[1]  = colour_load;
   assign word_ld[2]  = colour_load;
   assign word_ld[3]  = colour_load;
   assign word_ld[4]  = prox_done;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_word
         // low byte of word gi sits at 0x14 + 2*gi  see R15
         wire rd_lo = reg_rd & hit(reg_addr, 8'(`CPS_OFS_CLEAR_LO + 2 * gi));
         cps_word_shadow u_word (
            .clock   (clock),
            .resetn  (resetn),
            .load    (word_ld[gi]),
            .value   (word_val[gi]),
            .rd_lo   (rd_lo),
            .lo_byte (lo_b[gi]),
            .hi_byte (hi_b[gi])
         );
      end
   endgenerate

   // read data mux; unmapped offsets read zero
   wire [7:0] rd_mux =
      hit(reg_addr, `CPS_OFS_PULSE)    ? led_pulse_count_r :
      hit(reg_addr, `CPS_OFS_CONTROL)  ? analog_control_r  :
      hit(reg_addr, `CPS_OFS_IDENT)    ? PART_ID           : // see R7
      hit(reg_addr, `CPS_OFS_STATUS)   ? status_byte       :
      hit(reg_addr, `CPS_OFS_CLEAR_LO) ? lo_b[0] :
      hit(reg_addr, `CPS_OFS_CLEAR_HI) ? hi_b[0] :
      hit(reg_addr, `CPS_OFS_RED_LO)   ? lo_b[1] :
      hit(reg_addr, `CPS_OFS_RED_HI)   ? hi_b[1] :
      hit(reg_addr, `CPS_OFS_GREEN_LO) ? lo_b[2] :
      hit(reg_addr, `CPS_OFS_GREEN_HI) ? hi_b[2] :
      hit(reg_addr, `CPS_OFS_BLUE_LO)  ? lo_b[3] :
      hit(reg_addr, `CPS_OFS_BLUE_HI)  ? hi_b[3] :
      hit(reg_addr, `CPS_OFS_PROX_LO)  ? lo_b[4] :
      hit(reg_addr, `CPS_OFS_PROX_HI)  ? hi_b[4] : 8'h00;

   // read data registered on the strobe; the host reads it next cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rd_mux;
   end
endmodule : cps_sensor_regs
`default_nettype wire

// [design/cps_word_shadow.sv]
/*
 * one 16-bit result word with a read-coherent high-byte shadow.
 * assumes: rd_lo is a single-cycle pulse on clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cps_consts.svh"

module cps_word_shadow
   import cps_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // conversion result update
   input  wire logic        load,
   input  wire logic [15:0] value,
   // host byte reads
   input  wire logic        rd_lo,
   output logic      [7:0]  lo_byte,
   output logic      [7:0]  hi_byte
);
   logic [15:0] word_r;   // live result
   logic [7:0]  shadow_r; // high byte frozen by low read

   // live result, updated at end of each conversion
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) word_r <= `CPS_RST_RESULT;
      else if (load) word_r <= value;
   end

   // the shadow is taken from the live word, so a conversion landing
   // between the two byte reads never tears the pair (see R15) (see R16)
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) shadow_r <= 8'h00;
      else if (rd_lo) shadow_r <= word_r[15:8];
   end

   assign lo_byte = word_r[7:0];
   assign hi_byte = shadow_r; // see R15
endmodule : cps_word_shadow
`default_nettype wire

// [tb/cps_host.sv]
/*
 * host side model: issues register strobes as the i2c front end would.
 * assumes: strobes taken at a rising edge, read data one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module cps_host (
   // clock
   input wire logic       clock,
   // strobes toward the bank
   output var logic [7:0] reg_addr,
   output var logic       reg_wr,
   output var logic [7:0] reg_wdata,
   output var logic       reg_rd,
   input wire logic [7:0] reg_rdata
);
   // idle strobes from time zero
   initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   // one write, changed at the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
      @(negedge clock);
      reg_wr = 1'b0;
   endtask : wr
   // one read, data stands a cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clock);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clock);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask : rd
   // word read: low byte then high byte back to back
   task automatic rd_word(input logic [7:0] a, output logic [15:0] v);
      @(negedge clock);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clock);
      v[7:0] = reg_rdata;
      reg_addr = a + 8'h01;
      @(negedge clock);
      reg_rd = 1'b0;
      v[15:8] = reg_rdata;
   endtask : rd_word
endmodule : cps_host
`default_nettype wire

// [tb/cps_sensor_regs_checker.sv]
/*
 * port checker for the colour/proximity register bank.
 * assumes: bound onto cps_sensor_regs; one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cps_consts.svh"
module cps_sensor_regs_checker
   import cps_pkg::*;
#(
   parameter logic [7:0] PART_ID      = 8'h5A, // arbitrary identity value
   parameter int         STEP_CYCLES  = 2,
   parameter int         PULSE_CYCLES = 2
)
(
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // register strobes
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // sequencer side
   input wire logic        prox_enable,
   input wire logic        prox_irq_set,
   input wire logic [15:0] prox_value,
   input wire logic [1:0]  led_drive_strength,
   input wire logic [1:0]  prox_diode_select,
   input wire logic [1:0]  colour_gain,
   input wire logic        led_pulse,
   input wire logic        prox_measuring,
   input wire logic        colour_done,
   input wire logic        prox_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [15:0] pw_r;         // last loaded proximity word
   logic [7:0]  sh_r;         // expected shadow byte
   logic [7:0]  cnt_r, exp_r; // pulse count mirror, count of running phase
   logic [8:0]  pls_r;        // led pulses seen since colour end
   logic        ok_r, seen_r; // shadow usable, proximity phase seen
   // a low read on a load edge is ambiguous, so that shadow is not judged
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {pw_r, sh_r, cnt_r, exp_r, pls_r, ok_r, seen_r} <= '0;
      end else begin
         if (prox_done) pw_r <= prox_value;
         if (reg_rd && reg_addr == `CPS_OFS_PROX_LO) begin
            sh_r <= pw_r[15:8];
            ok_r <= !prox_done;
         end
         if (reg_wr && reg_addr == `CPS_OFS_PULSE) cnt_r <= reg_wdata;
         if (colour_done) begin
            {pls_r, seen_r} <= '0;
            exp_r <= cnt_r;
         end else begin
            if ($rose(led_pulse)) pls_r <= pls_r + 9'h001;
            if (prox_done) seen_r <= 1'b1;
         end
      end
   end
   property p_ident;
      reg_rd && reg_addr == `CPS_OFS_IDENT |=> reg_rdata == PART_ID;
   endproperty
   a_ident: assert property (p_ident) else $error("identity read wrong");
   property p_st_rsv;
      reg_rd && reg_addr == `CPS_OFS_STATUS |=> reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00;
   endproperty
   a_st_rsv: assert property (p_st_rsv) else $error("status reserved bits set");
   property p_prox_irq_flag;
      reg_rd && reg_addr == `CPS_OFS_STATUS && $past(prox_irq_set) |=> reg_rdata[5];
   endproperty
   a_prox_irq_flag: assert property (p_prox_irq_flag) else $error("proximity flag missing");
   property p_ctl_wr;
      logic [7:0] v;
      (reg_wr && reg_addr == `CPS_OFS_CONTROL, v = reg_wdata) |-> ##1
         led_drive_strength == v[7:6] && prox_diode_select == v[5:4] && colour_gain == v[1:0];
   endproperty
   a_ctl_wr: assert property (p_ctl_wr) else $error("control fields wrong");
   property p_ctl_rsv;
      reg_rd && reg_addr == `CPS_OFS_CONTROL |=> reg_rdata[3:2] == 2'b00;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
   property p_prox_after;
      colour_done && prox_enable |-> ##[0:1] prox_measuring;
   endproperty
   a_prox_after: assert property (p_prox_after) else $error("no proximity phase");
   property p_pulses;
      colour_done && seen_r |-> pls_r == {1'b0, exp_r};
   endproperty
   a_pulses: assert property (p_pulses) else $error("led pulse count wrong");
   property p_shadow;
      reg_rd && reg_addr == `CPS_OFS_PROX_HI && ok_r |=> reg_rdata == sh_r;
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow byte wrong");
   c_prox: cover property (colour_done && prox_enable);
   c_word: cover property (reg_rd && reg_addr == `CPS_OFS_PROX_LO ##1 reg_rd);
   c_ctl: cover property (reg_wr && reg_addr == `CPS_OFS_CONTROL);
endmodule : cps_sensor_regs_checker
`default_nettype wire

// [tb/tb_cps_sensor_regs.sv]
/*
 * self-checking bench for the colour/proximity register bank.
 * assumes: cps_host drives the strobes; analog side driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cps_sensor_regs
   import cps_pkg::*;
;
   localparam logic [7:0] PART_ID = 8'h3C; // arbitrary identity value
   typedef struct packed {logic wr; logic [7:0] a, d, e;} cps_row_t;
   // design pins, all idle from time zero
   logic        clock = 1'b0, resetn = 1'b0, colour_enable = 1'b0, prox_enable = 1'b0;
   logic        prox_irq_set = 1'b0, colour_irq_set = 1'b0, prox_irq_clr = 1'b0, colour_irq_clr = 1'b0;
   logic        reg_wr, reg_rd, led_pulse, colour_integrating, prox_measuring, colour_done, prox_done;
   logic [7:0]  colour_integration_time = 8'hFE, reg_addr, reg_wdata, reg_rdata, d;
   logic [15:0] clear_value, red_value, green_value, blue_value, prox_value, w;
   logic [1:0]  led_drive_strength, prox_diode_select, colour_gain;
   logic [15:0] col [5] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'hA55A}; // live channel values
   int          err_total = 0, tests_run = 0, i;
   // write rows, then reads with what they must return
   cps_row_t    rows [13] = '{'{1'b0, 8'h0E, 8'h00, 8'h00}, '{1'b0, 8'h0F, 8'h00, 8'h00},
      '{1'b0, 8'h12, 8'h00, PART_ID}, '{1'b0, 8'h13, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h00},
      '{1'b1, 8'h0E, 8'h03, 8'h00}, '{1'b0, 8'h0E, 8'h00, 8'h03}, '{1'b1, 8'h0F, 8'hFF, 8'h00},
      '{1'b0, 8'h0F, 8'h00, 8'hF3}, '{1'b1, 8'h12, 8'hAA, 8'h00}, '{1'b0, 8'h12, 8'h00, PART_ID},
      '{1'b1, 8'h13, 8'hFF, 8'h00}, '{1'b0, 8'h13, 8'h00, 8'h00}};
   always #10 clock = ~clock;
   assign {clear_value, red_value, green_value, blue_value, prox_value} = {col[0], col[1], col[2], col[3], col[4]};
   // short integration step keeps each cycle a handful of clocks
   cps_sensor_regs #(.PART_ID(PART_ID), .STEP_CYCLES(2), .PULSE_CYCLES(2)) cps_sensor_regs_i (.*);
   cps_host cps_host_i (.*);
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // bounded wait for the end of a proximity phase
   task automatic wait_prox();
      int n;
      for (n = 0; n < 200 && prox_done !== 1'b1; n++) @(negedge clock);
      chk(16'(n < 200), 16'h0001);
      @(negedge clock);
      chk(16'({colour_integrating, prox_measuring, led_pulse}), 16'h0004);
   endtask : wait_prox
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      repeat (8) @(negedge clock);
      resetn = 1'b1;
      foreach (rows[k]) begin
         if (rows[k].wr) begin
            cps_host_i.wr(rows[k].a, rows[k].d);
         end else begin
            cps_host_i.rd(rows[k].a, d);
            chk(16'(d), 16'(rows[k].e));
         end
      end
      $display("test table done");
      // every drive, diode and gain code
      for (i = 0; i < 4; i++) begin
         cps_host_i.wr(8'h0F, {i[1:0], i[1:0], 2'b00, i[1:0]});
         @(negedge clock);
         chk(16'({led_drive_strength, prox_diode_select, colour_gain}), 16'({3{i[1:0]}}));
      end
      $display("test codes done");
      {colour_enable, prox_enable} = 2'b11;
      wait_prox();
      wait_prox();
      cps_host_i.rd(8'h13, d);
      chk(16'(d), 16'h0003);
      for (i = 0; i < 5; i++) begin
         cps_host_i.rd_word(8'h14 + 8'(2 * i), w);
         chk(w, col[i]);
      end
      $display("test results done");
      // new conversions between the two byte reads
      cps_host_i.rd(8'h1C, d);
      col[4] = 16'h3CC3;
      wait_prox();
      wait_prox();
      cps_host_i.rd(8'h1D, d);
      chk(16'(d), 16'h00A5);
      cps_host_i.rd_word(8'h1C, w);
      chk(w, 16'h3CC3);
      $display("test shadow done");
      prox_irq_set = 1'b1;
      cps_host_i.rd(8'h13, d);
      prox_irq_set = 1'b0;
      chk(16'(d), 16'h0023);
      {colour_irq_set, prox_irq_clr} = 2'b11;
      cps_host_i.rd(8'h13, d);
      chk(16'(d), 16'h0013);
      {colour_irq_set, prox_irq_clr, colour_irq_clr} = 3'b001;
      cps_host_i.rd(8'h13, d);
      colour_irq_clr = 1'b0;
      chk(16'(d), 16'h0003);
      $display("test irq done");
      // colour off: proximity still paced, colour words frozen
      colour_enable = 1'b0;
      col[0] = 16'h0F0F;
      wait_prox();
      wait_prox();
      cps_host_i.rd_word(8'h14, w);
      chk(w, 16'h1234);
      cps_host_i.rd(8'h13, d);
      chk(16'(d), 16'h0000);
      $display("test colour off done");
      // reset in mid run
      resetn = 1'b0;
      @(negedge clock);
      resetn = 1'b1;
      cps_host_i.rd(8'h0E, d);
      chk(16'(d), 16'h0000);
      chk(16'({led_drive_strength, prox_diode_select, colour_gain}), 16'h0000);
      $display("test reset done");
      results();
   end
   // watchdog: the run needs some two hundred cycles, allow fifty times that
   initial begin
      #200000;
      err_total++;
      results();
   end
endmodule : tb_cps_sensor_regs
bind cps_sensor_regs cps_sensor_regs_checker #(.PART_ID(PART_ID), .STEP_CYCLES(STEP_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES)) cps_sensor_regs_checker_i (.*);
`default_nettype wire
